// File: config_loader_pkg.sv
// constants, states and address map of the configuration download and update block
// assumes a 10 MHz core clock and a separate bus-side clock for host accesses
package config_loader_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 500000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FETCH_TIME_NS = 10000;
  localparam int FETCH_CYCLES = FETCH_TIME_NS / CLK_PERIOD_NS;

  localparam int PAGE_BYTES = 32;
  localparam int CFG_PAGES = 7;
  localparam int CFG_BYTES = CFG_PAGES * PAGE_BYTES;
  localparam int NVM_BYTES = 1024;
  localparam int NVM_PAGES = NVM_BYTES / PAGE_BYTES;
  localparam int SEQ_BASE = 512;
  localparam int SEQ_WORD_BYTES = 8;
  localparam logic [5:0] SEQ_RESERVED = 6'h3f;

  localparam logic [15:0] RAM_LAST = 16'h00df;
  localparam logic [15:0] NVM_FIRST = 16'hf800;
  localparam logic [15:0] NVM_LAST = 16'hfbff;
  localparam logic [15:0] UPD_ADDR = 16'h0090;
  localparam logic [15:0] UDL_ADDR = 16'h00d8;
  localparam logic [7:0] ERASE_CMD = 8'hfe;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  localparam int BIT_TRANSPARENT = 0;
  localparam int BIT_COMMIT = 1;
  localparam int BIT_ERASE_EN = 2;
  localparam int BIT_USER_DL = 0;
  localparam logic [7:0] UPD_MASK = 8'h05;

  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_STAGE,
    ST_COMMIT,
    ST_SETTLE,
    ST_FETCH,
    ST_IDLE
  } dl_state_type;

endpackage : config_loader_pkg

// File: config_download_update.sv
// configuration loader: nonvolatile store, double-buffered latches, sequencing state fetch
// assumes host requests arrive on link_clk, everything else runs on ref_clk
`timescale 1ns/100ps

// How it works
// R01 - copying starts only after the synchronised supply-above-lockout input is high
// R02 - power-up download fills every staging latch before any active latch changes
// R03 - once staging is full, all staging latches copy into active latches together
// R04 - half a millisecond after download, state word zero loads into the engine
// R05 - host accesses before download completes are refused; host waits for completion
// R06 - transparent bit set: latch writes reach staging and active at once
// R07 - transparent bit clear: latch writes reach staging only
// R08 - writing one to commit bit makes one copy pulse, staging into active
// R09 - active configuration stays unchanged while staged writes wait for commit
// R10 - nonvolatile writes obey the same transparent and commit settings
// R11 - page erase sets whole page to ones only when erase enable is high
// R12 - nonvolatile edits never touch the running latch configuration
// R13 - a reload command repeats the download, overwriting host latch edits
// R14 - sequencing states live in a 512-byte store, 63 usable 64-bit words
// R15 - each state advance fetches the next word, taking about ten microseconds
// R16 - no latch copy of states; host writes state words straight into storage
// R17 - pages 0 to 6 download at power-up and on user download bit 0
// R18 - erase enable is bit 2 of the update control register; erase command fe
// R19 - the commit bit never stores, so it always reads back zero
// R20 - a busy flag covers downloads and fetches; accesses then are refused
module config_download_update
  import config_loader_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES,
  parameter int FETCH_CYCLES_P = FETCH_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic link_clk,
  input wire logic host_valid,
  input wire logic host_read,
  input wire logic [7:0] host_cmd,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic host_pending,
  output logic host_done,
  output logic host_ack,
  output logic [7:0] host_rdata,
  input wire logic [7:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data,
  input wire logic seq_advance,
  input wire logic [5:0] seq_next_index,
  output logic [63:0] seq_word,
  output logic [5:0] seq_index,
  output logic busy,
  output logic cfg_loaded
);

  dl_state_type state_q;
  logic [7:0] stage_q [CFG_BYTES];
  logic [7:0] active_q [CFG_BYTES];
  logic [7:0] nvm_q [NVM_BYTES] = '{default: ERASED_BYTE};
  logic [7:0] ctrl_q;
  logic [7:0] idx_q;
  logic [15:0] cnt_q;
  logic boot_q;
  logic [5:0] fetch_idx_q;
  logic [63:0] seq_word_q;
  logic [5:0] seq_index_q;
  logic cfg_loaded_q;
  logic [7:0] cfg_rd_data_q;
  logic sup_s1_q, sup_s2_q, sup_s3_q, supply_ok_q;
  logic park_v_q;
  logic [9:0] park_addr_q;
  logic [7:0] park_data_q;
  logic rq_s1_q, rq_s2_q, rq_s3_q;
  logic resp_ack_q, ack_tgl_q;
  logic [7:0] resp_data_q;
  // link side
  logic lrst_s1_q, lrst_s2_q;
  logic req_tgl_q, pending_q, done_q, ack_q;
  logic [7:0] rdata_q;
  logic lk_read_q;
  logic [7:0] lk_cmd_q, lk_wdata_q;
  logic [15:0] lk_addr_q;
  logic ak_s1_q, ak_s2_q, ak_s3_q;

  // request decode; the held link fields are stable while a request is in flight
  wire new_req = rq_s2_q ^ rq_s3_q;
  wire busy_w = (state_q != ST_IDLE); // [R20]
  wire accept = new_req && !busy_w; // [R05]
  wire is_erase = !lk_read_q && (lk_cmd_q == ERASE_CMD);
  wire in_ram = (lk_addr_q <= RAM_LAST);
  wire in_nvm = (lk_addr_q >= NVM_FIRST) && (lk_addr_q <= NVM_LAST);
  wire is_upd = (lk_addr_q == UPD_ADDR);
  wire is_udl = (lk_addr_q == UDL_ADDR);
  wire [7:0] ram_idx = lk_addr_q[7:0];
  wire [9:0] nvm_idx = lk_addr_q[9:0];
  wire [4:0] erase_page = lk_addr_q[9:5];
  wire transparent = ctrl_q[BIT_TRANSPARENT];
  wire erase_en = ctrl_q[BIT_ERASE_EN];
  wire wr = accept && !lk_read_q && !is_erase;
  wire ram_wr = wr && in_ram && !is_upd && !is_udl;
  wire upd_wr = wr && is_upd;
  wire commit_go = upd_wr && lk_wdata_q[BIT_COMMIT]; // [R08]
  wire dl_go = wr && is_udl && lk_wdata_q[BIT_USER_DL]; // [R13] [R17]
  wire nvm_wr = wr && in_nvm;
  wire nvm_wr_now = nvm_wr && transparent; // [R10]
  wire park_full = nvm_wr && !transparent && park_v_q;
  wire nvm_park = nvm_wr && !transparent && !park_v_q;
  wire park_commit = commit_go && park_v_q;
  wire erase_go = accept && is_erase && in_nvm && erase_en; // [R11] [R18]
  wire nack = busy_w || (!in_ram && !in_nvm) || park_full; // [R05]
  wire [7:0] rd_mux = is_upd ? ctrl_q :
                      in_nvm ? nvm_q[nvm_idx] :
                      (in_ram && !is_udl) ? active_q[ram_idx] : 8'h00;
  wire stage_load = (state_q == ST_STAGE);
  wire copy_all = (state_q == ST_COMMIT) || commit_go; // [R03] [R08]
  wire seq_go = seq_advance && !busy_w && (seq_next_index != SEQ_RESERVED); // [R14]
  wire stage_last = (idx_q == 8'(CFG_BYTES - 1));
  wire settle_last = (cnt_q == 16'(SETTLE_CYCLES_P - 1));
  wire fetch_last = (cnt_q == 16'(FETCH_CYCLES_P - 1));
  wire [9:0] seq_base_idx = 10'(SEQ_BASE) + {1'b0, fetch_idx_q, 3'b000};

  // supply comparator and request toggle both come from outside this clock
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      {sup_s1_q, sup_s2_q, sup_s3_q, supply_ok_q} <= 4'h0;
      {rq_s1_q, rq_s2_q, rq_s3_q} <= 3'h0;
    end else if (clk_en) begin
      {sup_s1_q, sup_s2_q, sup_s3_q} <= {supply_ok, sup_s1_q, sup_s2_q};
      {rq_s1_q, rq_s2_q, rq_s3_q} <= {req_tgl_q, rq_s1_q, rq_s2_q};
      if (sup_s2_q == sup_s3_q) begin
        supply_ok_q <= sup_s3_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= ST_LOCKOUT;
      idx_q <= 8'h00;
      cnt_q <= 16'h0000;
      boot_q <= 1'b1;
      fetch_idx_q <= 6'h00;
    end else if (clk_en) begin
      case (state_q)
        ST_LOCKOUT: begin
          if (supply_ok_q) begin // [R01]
            state_q <= ST_STAGE;
            idx_q <= 8'h00;
          end
        end
        ST_STAGE: begin
          idx_q <= idx_q + 8'h01;
          if (stage_last) begin // [R02]
            state_q <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          cnt_q <= 16'h0000;
          state_q <= boot_q ? ST_SETTLE : ST_IDLE;
        end
        ST_SETTLE: begin
          cnt_q <= cnt_q + 16'h0001;
          if (settle_last) begin // [R04]
            state_q <= ST_FETCH;
            cnt_q <= 16'h0000;
            fetch_idx_q <= 6'h00;
          end
        end
        ST_FETCH: begin
          cnt_q <= cnt_q + 16'h0001;
          if (fetch_last) begin // [R15]
            state_q <= ST_IDLE;
            boot_q <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (dl_go) begin // [R13]
            state_q <= ST_STAGE;
            idx_q <= 8'h00;
          end else if (seq_go) begin // [R15]
            state_q <= ST_FETCH;
            cnt_q <= 16'h0000;
            fetch_idx_q <= seq_next_index;
          end
        end
        default: state_q <= ST_LOCKOUT;
      endcase
    end
  end

  // commit is never stored so it reads back zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_q <= 8'h00;
    end else if (clk_en && upd_wr) begin
      ctrl_q <= lk_wdata_q & UPD_MASK; // [R19]
    end
  end

  // one parked nonvolatile write; a second one before commit is refused
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      park_v_q <= 1'b0;
      park_addr_q <= 10'h000;
      park_data_q <= 8'h00;
    end else if (clk_en) begin
      if (nvm_park) begin // [R10]
        park_v_q <= 1'b1;
        park_addr_q <= nvm_idx;
        park_data_q <= lk_wdata_q;
      end else if (park_commit) begin
        park_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resp_ack_q <= 1'b0;
      resp_data_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (clk_en && new_req) begin
      resp_ack_q <= !nack; // [R05] [R20]
      resp_data_q <= lk_read_q ? rd_mux : 8'h00;
      ack_tgl_q <= !ack_tgl_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_BYTES; gi++) begin : g_latch
      wire hit = ram_wr && (ram_idx == 8'(gi));
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          stage_q[gi] <= LATCH_RESET;
        end else if (clk_en) begin
          if (stage_load && (idx_q == 8'(gi))) begin
            stage_q[gi] <= nvm_q[gi]; // [R02] [R17]
          end else if (hit) begin
            stage_q[gi] <= lk_wdata_q; // [R07]
          end
        end
      end
      // active copies only on the copy step or a transparent write
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          active_q[gi] <= LATCH_RESET;
        end else if (clk_en) begin
          if (copy_all) begin
            active_q[gi] <= stage_q[gi]; // [R03] [R09]
          end else if (hit && transparent) begin
            active_q[gi] <= lk_wdata_q; // [R06]
          end
        end
      end
    end
    // nonvolatile bytes keep their value through reset; they start erased
    for (gi = 0; gi < NVM_BYTES; gi++) begin : g_nvm
      wire own_page = (erase_page == 5'(gi / PAGE_BYTES));
      wire hit_now = nvm_wr_now && (nvm_idx == 10'(gi));
      wire hit_park = park_commit && (park_addr_q == 10'(gi));
      always_ff @(posedge ref_clk) begin
        if (clk_en) begin
          if (erase_go && own_page) begin
            nvm_q[gi] <= ERASED_BYTE; // [R11]
          end else if (hit_now) begin
            nvm_q[gi] <= nvm_q[gi] & lk_wdata_q; // [R12] [R16]
          end else if (hit_park) begin
            nvm_q[gi] <= nvm_q[gi] & park_data_q; // [R10]
          end
        end
      end
    end
    for (gi = 0; gi < SEQ_WORD_BYTES; gi++) begin : g_seq
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          seq_word_q[8*gi +: 8] <= 8'h00;
        end else if (clk_en && (state_q == ST_FETCH) && fetch_last) begin
          seq_word_q[8*gi +: 8] <= nvm_q[seq_base_idx + 10'(gi)]; // [R14] [R15]
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_index_q <= 6'h00;
      cfg_loaded_q <= 1'b0;
      cfg_rd_data_q <= 8'h00;
    end else if (clk_en) begin
      if ((state_q == ST_FETCH) && fetch_last) begin
        seq_index_q <= fetch_idx_q;
      end
      if (state_q == ST_COMMIT) begin
        cfg_loaded_q <= 1'b1;
      end
      cfg_rd_data_q <= (cfg_rd_addr < 8'(CFG_BYTES)) ? active_q[cfg_rd_addr] : 8'h00;
    end
  end

  logic busy_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b1;
    end else if (clk_en) begin
      busy_q <= busy_w; // [R20]
    end
  end

  // link domain: reset follows reset_n through two stages
  always_ff @(posedge link_clk) begin
    lrst_s1_q <= reset_n;
    lrst_s2_q <= lrst_s1_q;
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q) begin
      {ak_s1_q, ak_s2_q, ak_s3_q} <= 3'h0;
    end else begin
      {ak_s1_q, ak_s2_q, ak_s3_q} <= {ack_tgl_q, ak_s1_q, ak_s2_q};
    end
  end

  // request fields stay frozen while pending, so the core may read them directly
  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q) begin
      req_tgl_q <= 1'b0;
      pending_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      lk_read_q <= 1'b0;
      lk_cmd_q <= 8'h00;
      lk_addr_q <= 16'h0000;
      lk_wdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (host_valid && !pending_q) begin
        req_tgl_q <= !req_tgl_q;
        pending_q <= 1'b1;
        lk_read_q <= host_read;
        lk_cmd_q <= host_cmd;
        lk_addr_q <= host_addr;
        lk_wdata_q <= host_wdata;
      end else if (ak_s2_q ^ ak_s3_q) begin
        pending_q <= 1'b0;
        done_q <= 1'b1;
        ack_q <= resp_ack_q;
        rdata_q <= resp_data_q;
      end
    end
  end

  assign host_pending = pending_q;
  assign host_done = done_q;
  assign host_ack = ack_q;
  assign host_rdata = rdata_q;
  assign cfg_rd_data = cfg_rd_data_q;
  assign seq_word = seq_word_q;
  assign seq_index = seq_index_q;
  assign busy = busy_q;
  assign cfg_loaded = cfg_loaded_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_stage_done;
    (state_q == ST_STAGE) && stage_last && clk_en;
  endsequence

  sequence s_fetch_start;
    (state_q == ST_IDLE) && seq_go && !dl_go && clk_en;
  endsequence

  lockout_hold_a: assert property ((state_q == ST_LOCKOUT) && !supply_ok_q |=> // [R01]
    state_q == ST_LOCKOUT) else $error("download left lockout without supply");
  stage_order_a: assert property (s_stage_done |=> (state_q == ST_COMMIT)) // [R02]
    else $error("staging did not end in the copy step");
  stage_hold_a: assert property ((state_q == ST_STAGE) && clk_en |=> // [R02]
    active_q[0] == $past(active_q[0])) else $error("active latch moved during staging");
  copy_all_a: assert property ((state_q == ST_COMMIT) && clk_en |=> // [R03]
    active_q[CFG_BYTES-1] == $past(stage_q[CFG_BYTES-1]))
    else $error("active latch missed the copy step");
  settle_end_a: assert property ((state_q == ST_SETTLE) && settle_last && clk_en |=> // [R04]
    (state_q == ST_FETCH) && (fetch_idx_q == 6'h00)) else $error("first state fetch late");
  busy_nack_a: assert property (new_req && busy_w && clk_en |=> !resp_ack_q) // [R05]
    else $error("access acknowledged while busy");
  staged_hold_a: assert property (ram_wr && !transparent && clk_en |=> // [R07]
    active_q[$past(ram_idx)] == $past(active_q[ram_idx])) else $error("staged write leaked");
  transparent_wr_a: assert property (ram_wr && transparent && clk_en |=> // [R06]
    active_q[$past(ram_idx)] == $past(lk_wdata_q)) else $error("transparent write lost");
  commit_pulse_a: assert property (commit_go && clk_en |=> // [R08]
    (active_q[0] == $past(stage_q[0])) && !ctrl_q[BIT_COMMIT]) else $error("commit failed");
  erase_gate_a: assert property (accept && is_erase && !erase_en && in_nvm && clk_en |=> // [R11]
    nvm_q[$past(nvm_idx)] == $past(nvm_q[nvm_idx])) else $error("erase while disabled");
  fetch_time_a: assert property (s_fetch_start |=> (state_q == ST_FETCH)[*8] // [R15]
    ##[1:400] (state_q == ST_IDLE)) else $error("state fetch timing wrong");

endmodule : config_download_update

// File: host_model.sv
// host-side request model for the link port of the configuration loader
// assumes link_clk clocks the link logic; requests change 1 ns after its rising edge
`timescale 1ns/100ps

module host_model (
  input wire logic link_clk,
  input wire logic host_pending,
  input wire logic host_done,
  input wire logic host_ack,
  input wire logic [7:0] host_rdata,
  output logic host_valid,
  output logic host_read,
  output logic [7:0] host_cmd,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic stuck
);

  initial begin
    host_valid = 1'b0;
    host_read = 1'b0;
    host_cmd = 8'h00;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    stuck = 1'b0;
  end

  // one request outstanding, held until the answer is seen
  task automatic access(input logic is_rd, input logic [7:0] cmd, input logic [15:0] addr,
      input logic [7:0] wd, output logic ack, output logic [7:0] rdat);
    int n;
    n = 0;
    @(posedge link_clk);
    #1;
    host_valid = 1'b1;
    host_read = is_rd;
    host_cmd = cmd;
    host_addr = addr;
    host_wdata = wd;
    do begin
      @(posedge link_clk);
      #1;
      n++;
    end while (host_done !== 1'b1 && n < 400);
    ack = host_ack;
    rdat = host_rdata;
    stuck = (n >= 400);
    // released lines show the inverse so a stale value is never mistaken for a live one
    host_valid = 1'b0;
    host_read = ~is_rd;
    host_cmd = ~cmd;
    host_addr = ~addr;
    host_wdata = ~wd;
  endtask : access

endmodule : host_model

// File: config_download_update_bench.sv
// self-checking bench for the configuration loader, host requests through host_model
// assumes shortened settle and fetch counts; nonvolatile store starts erased
`timescale 1ns/100ps

module config_download_update_bench;
  import config_loader_pkg::*;
  localparam int SET_P = 20;
  localparam int FET_P = 10;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n, supply_ok, seq_advance, clk_en;
  logic [5:0] seq_next_index, seq_index;
  logic [7:0] cfg_rd_addr, cfg_rd_data, host_cmd, host_wdata, host_rdata;
  logic [15:0] host_addr;
  logic [63:0] seq_word;
  logic host_valid, host_read, host_pending, host_done, host_ack, busy, cfg_loaded, stuck;
  int fail_count = 0;
  int cmp_count = 0;

  always #50 ref_clk = ~ref_clk;
  // rising edges of the 6 ns clock never coincide with the rising 100 ns core edges
  always #3 link_clk = ~link_clk;

  config_download_update #(.SETTLE_CYCLES_P(SET_P), .FETCH_CYCLES_P(FET_P)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .supply_ok(supply_ok),
    .link_clk(link_clk), .host_valid(host_valid), .host_read(host_read),
    .host_cmd(host_cmd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_pending(host_pending), .host_done(host_done), .host_ack(host_ack),
    .host_rdata(host_rdata), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
    .seq_advance(seq_advance), .seq_next_index(seq_next_index), .seq_word(seq_word),
    .seq_index(seq_index), .busy(busy), .cfg_loaded(cfg_loaded));

  host_model u_host (.link_clk(link_clk), .host_pending(host_pending),
    .host_done(host_done), .host_ack(host_ack), .host_rdata(host_rdata),
    .host_valid(host_valid), .host_read(host_read), .host_cmd(host_cmd),
    .host_addr(host_addr), .host_wdata(host_wdata), .stuck(stuck));

  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check

  task automatic acc(input logic is_rd, input logic [7:0] cmd, input logic [15:0] addr,
      input logic [7:0] wd, input logic exp_ack, input logic [7:0] exp_rd);
    logic ack;
    logic [7:0] rdat;
    u_host.access(is_rd, cmd, addr, wd, ack, rdat);
    if (stuck) begin
      check("host_done", 1, 0);
      conclude();
    end
    check("host_ack", exp_ack, ack);
    check("host_pending", 0, host_pending);
    if (is_rd && exp_ack) begin
      check("host_rdata", exp_rd, rdat);
    end
  endtask : acc

  task automatic wr(input logic [15:0] addr, input logic [7:0] d, input logic ack);
    acc(1'b0, 8'h00, addr, d, ack, 8'h00);
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp, input logic ack);
    acc(1'b1, 8'h00, addr, 8'h00, ack, exp);
  endtask : rd

  task automatic latch(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    cfg_rd_addr = idx;
    repeat (2) @(posedge ref_clk);
    #1;
    check("cfg_rd_data", exp, cfg_rd_data);
  endtask : latch

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (busy !== 1'b0) begin
      check("busy", 0, busy);
      conclude();
    end
  endtask : wait_idle

  task automatic advance(input logic [5:0] idx);
    @(posedge ref_clk);
    #1;
    seq_next_index = idx;
    seq_advance = 1'b1;
    @(posedge ref_clk);
    #1;
    seq_advance = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : advance

  initial begin
    int n;
    logic [63:0] exp_word;
    logic [7:0] d;
    reset_n = 1'b0;
    supply_ok = 1'b0;
    seq_advance = 1'b0;
    clk_en = 1'b1;
    seq_next_index = 6'h00;
    cfg_rd_addr = 8'h00;
    // two core cycles span dozens of link edges, ample for the link reset stages
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (30) @(posedge ref_clk);
    #1;
    check("cfg_loaded", 0, cfg_loaded);
    check("busy", 1, busy);
    latch(8'h00, LATCH_RESET);
    rd(UPD_ADDR, 8'h00, 1'b0);
    supply_ok = 1'b1;
    n = 0;
    while (cfg_loaded !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("cfg_loaded", 1, cfg_loaded);
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("settle_wait", 1, n >= SET_P + FET_P && n < 1000);
    if (busy !== 1'b0) conclude();
    check("seq_word", {64{1'b1}}, seq_word);
    check("seq_index", 0, seq_index);
    latch(8'h00, ERASED_BYTE);
    latch(8'hdf, ERASED_BYTE);
    latch(8'he0, 8'h00);
    wr(UPD_ADDR, 8'h01, 1'b1);
    wr(16'h0010, 8'h5a, 1'b1);
    latch(8'h10, 8'h5a);
    rd(UPD_ADDR, 8'h01, 1'b1);
    wr(UPD_ADDR, 8'h00, 1'b1);
    wr(16'h0010, 8'h3c, 1'b1);
    latch(8'h10, 8'h5a);
    wr(UPD_ADDR, 8'h02, 1'b1);
    latch(8'h10, 8'h3c);
    rd(UPD_ADDR, 8'h00, 1'b1);
    wr(16'hf820, 8'h12, 1'b1);
    rd(16'hf820, ERASED_BYTE, 1'b1);
    wr(16'hf821, 8'h34, 1'b0);
    wr(UPD_ADDR, 8'h02, 1'b1);
    rd(16'hf820, 8'h12, 1'b1);
    latch(8'h20, ERASED_BYTE);
    wr(UDL_ADDR, 8'h01, 1'b1);
    rd(UPD_ADDR, 8'h00, 1'b0);
    wait_idle();
    latch(8'h10, ERASED_BYTE);
    latch(8'h20, 8'h12);
    acc(1'b0, ERASE_CMD, 16'hf820, 8'h00, 1'b1, 8'h00);
    rd(16'hf820, 8'h12, 1'b1);
    wr(UPD_ADDR, 8'h04, 1'b1);
    acc(1'b0, ERASE_CMD, 16'hf820, 8'h00, 1'b1, 8'h00);
    rd(16'hf820, ERASED_BYTE, 1'b1);
    rd(16'hf83f, ERASED_BYTE, 1'b1);
    rd(16'h0100, 8'h00, 1'b0);
    // a state word is written byte by byte, straight into the store
    wr(UPD_ADDR, 8'h01, 1'b1);
    for (int b = 0; b < SEQ_WORD_BYTES; b++) begin
      d = (b == 0) ? 8'ha5 : 8'(b);
      exp_word[8*b +: 8] = d;
      wr(16'hfa08 + 16'(b), d, 1'b1);
    end
    advance(6'd1);
    check("busy", 1, busy);
    check("seq_index", 0, seq_index);
    wait_idle();
    check("seq_word", exp_word, seq_word);
    check("seq_index", 1, seq_index);
    advance(SEQ_RESERVED);
    check("busy", 0, busy);
    repeat (FET_P + 3) @(posedge ref_clk);
    #1;
    check("seq_index", 1, seq_index);
    // a frozen core must let an advance pulse pass unseen
    clk_en = 1'b0;
    advance(6'd2);
    check("busy", 0, busy);
    clk_en = 1'b1;
    repeat (FET_P + 3) @(posedge ref_clk);
    #1;
    check("seq_index", 1, seq_index);
    conclude();
  end

endmodule : config_download_update_bench
